/* src/bpc_ctrl.sv */
// bpc_ctrl: issues protection command sequences, tracks device mode.
// assumes one command at a time on the user port, flash pins on the far side.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_cfg.svh"
module bpc_ctrl
  import bpc_pkg::*;
#(
  parameter int AW = 23,
  parameter int DW = 8
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [DW-1:0] cmd_data,
  input wire logic [4*DW-1:0] cmd_pwd,
  output logic rsp_valid,
  output logic rsp_refused,
  output logic [4*DW-1:0] rsp_data,
  output logic [2:0] dev_mode,
  output logic [AW-1:0] flash_addr,
  output logic [DW-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [DW-1:0] flash_dq_in,
  output logic flash_ce_b,
  output logic flash_oe_b,
  output logic flash_we_b
);
  localparam int PW = 4 * DW;
  localparam int SW = AW + DW + 2;
  localparam logic [AW-1:0] BANK_MASK = ~((AW'(1) << `BPC_BANK_LSB) - AW'(1));
  localparam int GAP_CYC = `BPC_CYC(`BPC_T_UNLOCK_GAP_NS);

  // ************************************************
  // state
  // ************************************************
  bpc_state_e state, next_state;
  bpc_op_e op, next_op;
  bpc_mode_e mode, next_mode;
  logic [AW-1:0] addr, next_addr;
  logic [DW-1:0] data, next_data;
  logic [PW-1:0] pwd, next_pwd;
  logic [2:0] idx, next_idx;
  logic next_cmd_ready, next_rsp_valid, next_rsp_refused;
  logic [PW-1:0] next_rsp_data;
  logic next_req, next_rd;
  logic [AW-1:0] next_caddr;
  logic [DW-1:0] next_cwdata;
  logic [SW-1:0] step;
  logic gap_ok, gap_start;

  bpc_cyc_if #(.AW(AW), .DW(DW)) cyc ();

  // ************************************************
  // functions
  // ************************************************
  // one bus step packed as {rd, last, addr, data}
  function automatic logic [SW-1:0] mk(input logic r, input logic l,
                                       input logic [AW-1:0] a, input logic [DW-1:0] d);
    mk = {r, l, a, d};
  endfunction : mk

  function automatic logic blk0(input logic [AW-1:0] a);
    blk0 = (a <= AW'(`BPC_BLK0_LAST));
  endfunction : blk0

  function automatic logic prot(input bpc_mode_e m);
    prot = (m != MD_READ) && (m != MD_EXT);
  endfunction : prot

  // which commands the tracked mode allows
  function automatic logic legal(input bpc_op_e o, input bpc_mode_e m,
                                 input logic [AW-1:0] a);
    logic guard;
    guard = (m == MD_NVB || m == MD_VOL) && blk0(a);
    legal = 1'b0;
    unique case (o)
      // array read only in read mode
      OP_ARRAY_READ: legal = (m == MD_READ);
      OP_ENTER_LOCK, OP_ENTER_PWD, OP_ENTER_NVB, OP_ENTER_LKB,
      OP_ENTER_VOL, OP_ENTER_EXT: legal = (m == MD_READ);
      OP_EXIT_PROT: legal = prot(m);
      OP_EXIT_EXT: legal = (m == MD_EXT);
      // block 0 kept out of NVB and VOL modes
      OP_PROGRAM, OP_STATUS_READ: legal = (m != MD_READ) && !guard;
      OP_VOL_CLEAR: legal = (m == MD_VOL) && !guard;
      OP_CLEAR_ALL: legal = (m == MD_NVB);
      OP_PWD_READ, OP_PWD_UNLOCK: legal = (m == MD_PWD);
      default: legal = 1'b0;
    endcase
  endfunction : legal

  function automatic logic [DW-1:0] entry_code(input bpc_op_e o);
    unique case (o)
      OP_ENTER_LOCK: entry_code = DW'(`BPC_DAT_LOCKREG);
      OP_ENTER_PWD: entry_code = DW'(`BPC_DAT_PWD);
      OP_ENTER_NVB: entry_code = DW'(`BPC_DAT_NVB);
      OP_ENTER_LKB: entry_code = DW'(`BPC_DAT_LKB);
      OP_ENTER_VOL: entry_code = DW'(`BPC_DAT_VOL);
      default: entry_code = DW'(`BPC_DAT_EXT);
    endcase
  endfunction : entry_code

  // bus step idx of command o
  function automatic logic [SW-1:0] step_of(input bpc_op_e o, input logic [2:0] i,
                                            input bpc_mode_e m, input logic [AW-1:0] a,
                                            input logic [DW-1:0] d, input logic [PW-1:0] p);
    logic [AW-1:0] ul1;
    logic [AW-1:0] ul2;
    logic [1:0] wi;
    logic [DW-1:0] pd;
    logic [DW-1:0] gd;
    ul1 = AW'(`BPC_ADR_UL1);
    ul2 = AW'(`BPC_ADR_UL2);
    wi = 2'(i - 3'h2);
    pd = p[wi*DW +: DW];
    // guard modes always write the protect value
    gd = (m == MD_NVB || m == MD_LKB || m == MD_VOL) ? DW'(`BPC_DAT_GUARD_SET) : d;
    step_of = mk(1'b0, 1'b1, '0, '0);
    unique case (o)
      OP_ENTER_LOCK, OP_ENTER_PWD, OP_ENTER_NVB, OP_ENTER_LKB,
      OP_ENTER_VOL, OP_ENTER_EXT:
        if (i == 3'h0)
          step_of = mk(1'b0, 1'b0, ul1, DW'(`BPC_DAT_UL1));
        else if (i == 3'h1)
          step_of = mk(1'b0, 1'b0, ul2, DW'(`BPC_DAT_UL2));
        else
          step_of = mk(1'b0, 1'b1, (o == OP_ENTER_NVB || o == OP_ENTER_VOL) ?
                       ((a & BANK_MASK) | ul1) : ul1, entry_code(o));
      OP_EXIT_PROT:
        step_of = mk(1'b0, i != 3'h0, '0,
                     (i == 3'h0) ? DW'(`BPC_DAT_EXIT1) : DW'(`BPC_DAT_EXIT2));
      OP_EXIT_EXT:
        if (i == 3'h0)
          step_of = mk(1'b0, 1'b0, ul1, DW'(`BPC_DAT_UL1));
        else if (i == 3'h1)
          step_of = mk(1'b0, 1'b0, ul2, DW'(`BPC_DAT_UL2));
        else if (i == 3'h2)
          step_of = mk(1'b0, 1'b0, ul1, DW'(`BPC_DAT_EXIT1));
        else
          step_of = mk(1'b0, 1'b1, '0, DW'(`BPC_DAT_EXIT2));
      OP_PROGRAM:
        if (i == 3'h0)
          step_of = mk(1'b0, 1'b0, '0, DW'(`BPC_DAT_PROG));
        else if (m == MD_LOCK || m == MD_LKB)
          step_of = mk(1'b0, 1'b1, '0, gd);
        else if (m == MD_PWD)
          step_of = mk(1'b0, 1'b1, AW'(a[1:0]), d);
        else
          step_of = mk(1'b0, 1'b1, a, gd);
      // volatile clear writes the unprotected value
      OP_VOL_CLEAR:
        step_of = mk(1'b0, i != 3'h0, (i == 3'h0) ? '0 : a,
                     (i == 3'h0) ? DW'(`BPC_DAT_PROG) : DW'(`BPC_DAT_GUARD_CLR));
      // clear-all, 80 then 30 at 00
      OP_CLEAR_ALL:
        step_of = mk(1'b0, i != 3'h0, '0,
                     (i == 3'h0) ? DW'(`BPC_DAT_ERASE1) : DW'(`BPC_DAT_ERASE2));
      OP_ARRAY_READ, OP_STATUS_READ:
        step_of = mk(1'b1, 1'b1, a, '0);
      // all four words, 00 to 03
      OP_PWD_READ:
        step_of = mk(1'b1, i == 3'h3, AW'(i[1:0]), '0);
      OP_PWD_UNLOCK:
        if (i == 3'h0)
          step_of = mk(1'b0, 1'b0, '0, DW'(`BPC_DAT_PUL1));
        else if (i == 3'h1)
          step_of = mk(1'b0, 1'b0, '0, DW'(`BPC_DAT_PUL2));
        else if (i == 3'h6)
          step_of = mk(1'b0, 1'b1, '0, DW'(`BPC_DAT_PUL3));
        else
          step_of = mk(1'b0, 1'b0, AW'(wi), pd);
      default: step_of = mk(1'b0, 1'b1, '0, '0);
    endcase
  endfunction : step_of

  function automatic bpc_mode_e mode_after(input bpc_op_e o, input bpc_mode_e m);
    unique case (o)
      OP_ENTER_LOCK: mode_after = MD_LOCK;
      OP_ENTER_PWD: mode_after = MD_PWD;
      OP_ENTER_NVB: mode_after = MD_NVB;
      OP_ENTER_LKB: mode_after = MD_LKB;
      OP_ENTER_VOL: mode_after = MD_VOL;
      OP_ENTER_EXT: mode_after = MD_EXT;
      OP_EXIT_PROT, OP_EXIT_EXT: mode_after = MD_READ;
      default: mode_after = m;
    endcase
  endfunction : mode_after

  // ************************************************
  // command sequencer
  // ************************************************
  assign step = step_of(op, idx, mode, addr, data, pwd);

  // next-state and step issue
  always_comb
  begin
    next_state = state;
    next_op = op;
    next_mode = mode;
    next_addr = addr;
    next_data = data;
    next_pwd = pwd;
    next_idx = idx;
    next_rsp_valid = 1'b0;
    next_rsp_refused = 1'b0;
    next_rsp_data = rsp_data;
    next_req = 1'b0;
    next_rd = cyc.rd;
    next_caddr = cyc.addr;
    next_cwdata = cyc.wdata;
    gap_start = 1'b0;
    unique case (state)
      ST_IDLE:
        if (cmd_valid && cmd_ready)
        begin
          next_op = bpc_op_e'(cmd_op);
          next_addr = cmd_addr;
          next_data = cmd_data;
          next_pwd = cmd_pwd;
          next_idx = 3'h0;
          next_rsp_data = '0;
          if (legal(bpc_op_e'(cmd_op), mode, cmd_addr))
            next_state = ST_ISSUE;
          else
          begin
            next_rsp_refused = 1'b1;
            next_state = ST_RESP;
          end
        end
      ST_ISSUE:
        // hold a new unlock until the spacing has passed
        if (op != OP_PWD_UNLOCK || idx != 3'h0 || gap_ok)
        begin
          next_req = 1'b1;
          next_rd = step[SW-1];
          // upper lines of don't-care steps driven low
          next_caddr = step[AW+DW-1:DW];
          next_cwdata = step[DW-1:0];
          next_state = ST_WAIT;
        end
      ST_WAIT:
        if (cyc.done)
        begin
          // guard status keeps bit 0 only
          if (cyc.rd && op == OP_PWD_READ)
            next_rsp_data[idx[1:0]*DW +: DW] = cyc.rdata;
          else if (cyc.rd && (mode inside {MD_NVB, MD_LKB, MD_VOL}))
            next_rsp_data = PW'(cyc.rdata[0]);
          else if (cyc.rd)
            next_rsp_data = PW'(cyc.rdata);
          if (step[SW-2])
          begin
            next_mode = mode_after(op, mode);
            gap_start = (op == OP_PWD_UNLOCK);
            next_state = ST_RESP;
          end
          else
          begin
            next_idx = idx + 3'h1;
            next_state = ST_ISSUE;
          end
        end
      ST_RESP:
      begin
        next_rsp_valid = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
    next_cmd_ready = (next_state == ST_IDLE);
    if (state == ST_RESP)
      next_rsp_refused = rsp_refused;
  end

  // sequencer registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      op <= OP_ARRAY_READ;
      mode <= MD_READ;
      addr <= '0;
      data <= '0;
      pwd <= '0;
      idx <= 3'h0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_refused <= 1'b0;
      rsp_data <= '0;
      cyc.req <= 1'b0;
      cyc.rd <= 1'b0;
      cyc.addr <= '0;
      cyc.wdata <= '0;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      mode <= next_mode;
      addr <= next_addr;
      data <= next_data;
      pwd <= next_pwd;
      idx <= next_idx;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_refused <= next_rsp_refused;
      rsp_data <= next_rsp_data;
      cyc.req <= next_req;
      cyc.rd <= next_rd;
      cyc.addr <= next_caddr;
      cyc.wdata <= next_cwdata;
    end
  end

  assign dev_mode = mode;

  // ************************************************
  // bus cycle engine and unlock spacing
  // ************************************************
  bpc_bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .clk(clk),
    .rst_b(rst_b),
    .cyc(cyc),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_b(flash_ce_b),
    .flash_oe_b(flash_oe_b),
    .flash_we_b(flash_we_b)
  );

  bpc_gap_timer #(.GAP_CYC(GAP_CYC)) u_gap (
    .clk(clk),
    .rst_b(rst_b),
    .start(gap_start),
    .ok(gap_ok)
  );
endmodule : bpc_ctrl
`default_nettype wire

/* pkg/bpc_cfg.svh */
// bpc_cfg.svh: numbers of the block-protection controller.
// assumes a byte-mode flash bus and a 100 MHz controller clock.
`ifndef BPC_CFG_SVH
`define BPC_CFG_SVH
// ns to cycles, rounded up
`define BPC_CLK_MHZ 100
`define BPC_CYC(ns) ((((ns) * `BPC_CLK_MHZ) + 999) / 1000)
// bus cycle timing in ns, read sync stages in cycles
`define BPC_T_SETUP_NS 20
`define BPC_T_WP_NS 40
`define BPC_T_HOLD_NS 20
`define BPC_T_ACC_NS 80
`define BPC_SYNC_CYC 3
// unlock spacing, ns
`define BPC_T_UNLOCK_GAP_NS 1000
// unlock cycle addresses and data
`define BPC_ADR_UL1 12'hAAA
`define BPC_ADR_UL2 12'h555
`define BPC_DAT_UL1 8'hAA
`define BPC_DAT_UL2 8'h55
// entry, exit and command codes
`define BPC_DAT_LOCKREG 8'h40
`define BPC_DAT_PWD 8'h60
`define BPC_DAT_NVB 8'hC0
`define BPC_DAT_LKB 8'h50
`define BPC_DAT_VOL 8'hE0
`define BPC_DAT_EXT 8'h88
`define BPC_DAT_EXIT1 8'h90
`define BPC_DAT_EXIT2 8'h00
`define BPC_DAT_PROG 8'hA0
`define BPC_DAT_ERASE1 8'h80
`define BPC_DAT_ERASE2 8'h30
`define BPC_DAT_PUL1 8'h25
`define BPC_DAT_PUL2 8'h03
`define BPC_DAT_PUL3 8'h29
`define BPC_DAT_GUARD_SET 8'h00
`define BPC_DAT_GUARD_CLR 8'h01
// bank low bit, last byte of block 0
`define BPC_BANK_LSB 21
`define BPC_BLK0_LAST 23'h001FFF
`endif

/* pkg/bpc_pkg.sv */
// bpc_pkg: controller types.
// assumes bpc_cfg.svh for all numbers.
package bpc_pkg;
  // user command codes
  typedef enum logic [3:0] {
    OP_ARRAY_READ = 4'h0, OP_ENTER_LOCK = 4'h1, OP_ENTER_PWD = 4'h2,
    OP_ENTER_NVB = 4'h3, OP_ENTER_LKB = 4'h4, OP_ENTER_VOL = 4'h5,
    OP_ENTER_EXT = 4'h6, OP_EXIT_PROT = 4'h7, OP_EXIT_EXT = 4'h8,
    OP_PROGRAM = 4'h9, OP_VOL_CLEAR = 4'hA, OP_CLEAR_ALL = 4'hB,
    OP_STATUS_READ = 4'hC, OP_PWD_READ = 4'hD, OP_PWD_UNLOCK = 4'hE
  } bpc_op_e;
  // device mode as tracked by the controller
  typedef enum logic [2:0] {
    MD_READ = 3'h0, MD_LOCK = 3'h1, MD_PWD = 3'h2, MD_NVB = 3'h3,
    MD_LKB = 3'h4, MD_VOL = 3'h5, MD_EXT = 3'h6
  } bpc_mode_e;
  // command sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_ISSUE = 2'h1, ST_WAIT = 2'h2, ST_RESP = 2'h3
  } bpc_state_e;
  // bus cycle phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0, PH_SETUP = 2'h1, PH_STROBE = 2'h2, PH_HOLD = 2'h3
  } bpc_phase_e;
endpackage : bpc_pkg

/* pkg/bpc_cyc_if.sv */
// bpc_cyc_if: one bus cycle request and its completion.
// assumes both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface bpc_cyc_if #(
  parameter int AW = 23,
  parameter int DW = 8
);
  logic req;
  logic rd;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic done;
  logic [DW-1:0] rdata;
  modport ctl (output req, rd, addr, wdata, input done, rdata);
  modport eng (input req, rd, addr, wdata, output done, rdata);
endinterface : bpc_cyc_if
`default_nettype wire

/* src/bpc_gap_timer.sv */
// bpc_gap_timer: spacing between password unlocks.
// assumes start is a one-cycle pulse on clk.
`timescale 1ns/1ps
`default_nettype none
module bpc_gap_timer #(
  parameter int GAP_CYC = 100
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  output logic ok
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_ok;

  // count down from start, ok once elapsed
  always_comb
  begin
    next_cnt = cnt;
    next_ok = ok;
    if (start)
    begin
      next_cnt = 16'(GAP_CYC);
      next_ok = 1'b0;
    end
    else if (cnt > 16'h0001)
      next_cnt = cnt - 16'h0001;
    else
    begin
      next_cnt = 16'h0000;
      next_ok = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt <= 16'h0000;
      ok <= 1'b1;
    end
    else
    begin
      cnt <= next_cnt;
      ok <= next_ok;
    end
  end
endmodule : bpc_gap_timer
`default_nettype wire

/* src/bpc_bus_cycle.sv */
// bpc_bus_cycle: one asynchronous flash write or read cycle on the pins.
// assumes req pulses only while idle; dq input comes from a pin.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_cfg.svh"
module bpc_bus_cycle
  import bpc_pkg::*;
#(
  parameter int AW = 23,
  parameter int DW = 8
)(
  input wire logic clk,
  input wire logic rst_b,
  bpc_cyc_if.eng cyc,
  output logic [AW-1:0] flash_addr,
  output logic [DW-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [DW-1:0] flash_dq_in,
  output logic flash_ce_b,
  output logic flash_oe_b,
  output logic flash_we_b
);
  localparam logic [7:0] C_SET = 8'(`BPC_CYC(`BPC_T_SETUP_NS));
  localparam logic [7:0] C_WP = 8'(`BPC_CYC(`BPC_T_WP_NS));
  localparam logic [7:0] C_HOLD = 8'(`BPC_CYC(`BPC_T_HOLD_NS));
  localparam logic [7:0] C_ACC = 8'(`BPC_CYC(`BPC_T_ACC_NS) + `BPC_SYNC_CYC);

  bpc_phase_e ph, next_ph;
  logic [7:0] cnt, next_cnt;
  logic rd, next_rd;
  logic [AW-1:0] next_addr;
  logic [DW-1:0] next_dout, next_rdata;
  logic next_oe_en, next_ce_b, next_oe_b, next_we_b, next_done;
  logic [DW-1:0] s1, s2, s3;

  // phase sequencing of the strobes
  always_comb
  begin
    next_ph = ph;
    next_cnt = cnt;
    next_rd = rd;
    next_addr = flash_addr;
    next_dout = flash_dq_out;
    next_oe_en = flash_dq_oe;
    next_ce_b = flash_ce_b;
    next_oe_b = flash_oe_b;
    next_we_b = flash_we_b;
    next_rdata = cyc.rdata;
    next_done = 1'b0;
    unique case (ph)
      PH_IDLE:
        if (cyc.req)
        begin
          next_addr = cyc.addr;
          next_dout = cyc.wdata;
          next_rd = cyc.rd;
          next_oe_en = !cyc.rd;
          next_oe_b = !cyc.rd;
          next_ce_b = 1'b0;
          next_cnt = C_SET;
          next_ph = PH_SETUP;
        end
      PH_SETUP:
        if (cnt > 8'h01)
          next_cnt = cnt - 8'h01;
        else
        begin
          next_ph = PH_STROBE;
          next_cnt = rd ? C_ACC : C_WP;
          next_we_b = rd;
        end
      PH_STROBE:
        if (cnt > 8'h01)
          next_cnt = cnt - 8'h01;
        else if (!rd || s2 == s3)
        begin
          // read data taken once the last two stages agree
          if (rd)
            next_rdata = s3;
          next_we_b = 1'b1;
          next_oe_b = 1'b1;
          next_cnt = C_HOLD;
          next_ph = PH_HOLD;
        end
      PH_HOLD:
        if (cnt > 8'h01)
          next_cnt = cnt - 8'h01;
        else
        begin
          next_ce_b = 1'b1;
          next_oe_en = 1'b0;
          next_done = 1'b1;
          next_ph = PH_IDLE;
        end
    endcase
  end

  // registers, including the three-stage dq synchroniser
  always_ff @(posedge clk)
  begin
    s1 <= flash_dq_in;
    s2 <= s1;
    s3 <= s2;
    if (!rst_b)
    begin
      ph <= PH_IDLE;
      cnt <= 8'h00;
      rd <= 1'b0;
      flash_addr <= '0;
      flash_dq_out <= '0;
      flash_dq_oe <= 1'b0;
      flash_ce_b <= 1'b1;
      flash_oe_b <= 1'b1;
      flash_we_b <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end
    else
    begin
      ph <= next_ph;
      cnt <= next_cnt;
      rd <= next_rd;
      flash_addr <= next_addr;
      flash_dq_out <= next_dout;
      flash_dq_oe <= next_oe_en;
      flash_ce_b <= next_ce_b;
      flash_oe_b <= next_oe_b;
      flash_we_b <= next_we_b;
      cyc.done <= next_done;
      cyc.rdata <= next_rdata;
    end
  end
endmodule : bpc_bus_cycle
`default_nettype wire

/* verif/bpc_ctrl_properties.sv */
// bpc_ctrl_properties: port checks of bpc_ctrl.
// assumes bind into bpc_ctrl, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bpc_ctrl_properties #(
  parameter int AW = 23,
  parameter int DW = 8
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic rsp_valid,
  input wire logic rsp_refused,
  input wire logic [2:0] dev_mode,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_b,
  input wire logic flash_oe_b,
  input wire logic flash_we_b
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // command taken this edge
  logic take;
  assign take = cmd_valid && cmd_ready;
  AST_BAD_OP: assert property (take && cmd_op == 4'hF |-> ##2 rsp_valid && rsp_refused)
    else $error("bad op not refused");
  AST_ENTRY_OUT: assert property (take && cmd_op inside {[4'h1:4'h6]} && dev_mode != 3'h0 |-> ##2 rsp_refused)
    else $error("entry taken");
  AST_REFUSE_QUIET: assert property (take && cmd_op == 4'hF |-> flash_ce_b [*3])
    else $error("cycle on refusal");
  AST_WE_WIDTH: assert property ($fell(flash_we_b) |-> !flash_we_b [*4] ##1 flash_we_b)
    else $error("write strobe width");
  AST_WE_HOLD: assert property (!flash_we_b |-> !flash_ce_b && flash_dq_oe && $stable(flash_dq_out))
    else $error("write data moved");
  AST_SETUP: assert property ($fell(flash_we_b) |-> !$past(flash_ce_b, 2) && $stable(flash_addr))
    else $error("write setup short");
  AST_OE: assert property (!flash_oe_b |-> !flash_dq_oe && flash_we_b && !flash_ce_b)
    else $error("read while driving");
  AST_MODE_RSP: assert property ($changed(dev_mode) |-> ##1 rsp_valid && !rsp_refused)
    else $error("mode change unanswered");
  AST_READY_BACK: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid)
    else $error("ready not back");
  // main scenarios seen
  COV_UNLOCK: cover property (take && cmd_op == 4'hE);
  COV_REFUSE: cover property (rsp_valid && rsp_refused);
  COV_READ: cover property ($fell(flash_oe_b));
endmodule : bpc_ctrl_properties
bind bpc_ctrl bpc_ctrl_properties #(.AW(AW), .DW(DW)) u_props (.*);
`default_nettype wire

/* verif/bpc_flash_model.sv */
// bpc_flash_model: byte-mode flash answering protection commands.
// assumes the pins of bpc_ctrl; array reads give a fixed byte.
`timescale 1ns/1ps
`default_nettype none
module bpc_flash_model #(
  parameter int ACC_NS = 60
)(
  input wire logic [22:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  output logic [7:0] flash_dq_in,
  input wire logic flash_ce_b,
  input wire logic flash_oe_b,
  input wire logic flash_we_b
);
  // ****************
  // device state
  // ****************
  logic [2:0] mode = 3'h0;
  logic [3:0] st = 4'h0;
  logic [7:0] lockreg = 8'h00;
  logic [7:0] ext = 8'hFF;
  logic [7:0] pwd [4] = '{default: 8'hFF};
  logic [3:0] nv = 4'h0;
  logic [3:0] vb = 4'hF;
  logic lkb = 1'b1;
  logic ok;
  logic [7:0] d, rd;
  logic [11:0] a;
  logic [1:0] b;
  int unl_cnt = 0;
  realtime t_unl = -2000.0;
  // write decode, low byte and low address
  always @(posedge flash_we_b)
  begin
    if (flash_ce_b === 1'b0)
    begin
      {d, a, b} = {flash_dq_out, flash_addr[11:0], flash_addr[14:13]};
      if (st == 4'h0 && d == 8'hAA && a == 12'hAAA) st = 4'h1;
      else if (st == 4'h1 && d == 8'h55 && a == 12'h555) st = 4'h2;
      else if (st == 4'h2 && a == 12'hAAA && mode == 3'h6) st = (d == 8'h90) ? 4'h3 : 4'h0;
      else if (st == 4'h2 && a == 12'hAAA && mode == 3'h0)
      begin
        st = 4'h0;
        case (d)
          8'h40: mode = 3'h1;
          8'h60: mode = 3'h2;
          8'hC0: mode = 3'h3;
          8'h50: mode = 3'h4;
          8'hE0: mode = 3'h5;
          8'h88: mode = 3'h6;
          default: mode = 3'h0;
        endcase
      end
      else if ((st == 4'h3 || st == 4'h5) && d == 8'h00) {mode, st} = 7'h00;
      else if (st == 4'h0 && d == 8'h90 && mode inside {[3'h1:3'h5]}) st = 4'h5;
      else if (st == 4'h4 && !(mode inside {3'h3, 3'h5} && flash_addr <= 23'h001FFF))
      begin
        st = 4'h0;
        case (mode)
          3'h1: lockreg = d;
          3'h2: pwd[a[1:0]] = d;
          3'h3: nv[b] = (d == 8'h00);
          3'h4: lkb = (d != 8'h00);
          3'h5: vb[b] = d[0];
          default: ext = d;
        endcase
      end
      else if (st == 4'h0 && d == 8'hA0 && mode != 3'h0) st = 4'h4;
      // clear-all only while lock bit is 1
      else if (st == 4'h0 && d == 8'h80 && mode == 3'h3) st = 4'h6;
      else if (st == 4'h6 && d == 8'h30) {st, nv} = {4'h0, lkb ? 4'h0 : nv};
      else if (st == 4'h0 && d == 8'h25 && mode == 3'h2) {st, ok} = {4'h7, 1'b1};
      else if (st == 4'h7 && d == 8'h03) st = 4'h8;
      else if (st >= 4'h8 && st <= 4'hB) {st, ok} = {st + 4'h1, ok && d == pwd[st[1:0]] && a[1:0] == st[1:0]};
      else if (st == 4'hC && d == 8'h29)
      begin
        st = 4'h0;
        unl_cnt += (ok && $realtime - t_unl >= 1000.0) ? 1 : 0;
        t_unl = $realtime;
      end
      else st = 4'h0;
    end
  end
  always_comb
  begin
    case (mode)
      3'h0: rd = 8'h5A;
      3'h1: rd = lockreg;
      3'h2: rd = pwd[flash_addr[1:0]];
      3'h3: rd = {7'h0, !nv[flash_addr[14:13]]};
      3'h4: rd = {7'h0, lkb};
      3'h5: rd = {7'h0, vb[flash_addr[14:13]] && !nv[flash_addr[14:13]]};
      default: rd = ext;
    endcase
  end
  // released bus shows the inverse, data after access time
  assign #(ACC_NS) flash_dq_in = (!flash_ce_b && !flash_oe_b) ? rd : ~rd;
endmodule : bpc_flash_model
`default_nettype wire

/* verif/bpc_ctrl_tb.sv */
// bpc_ctrl_tb: self-checking bench of bpc_ctrl with a flash model.
// assumes bpc_flash_model on the pins and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module bpc_ctrl_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready, rsp_valid, rsp_refused, flash_dq_oe, flash_ce_b, flash_oe_b, flash_we_b;
  logic [3:0] cmd_op = 4'h0;
  logic [22:0] cmd_addr = 23'h0, flash_addr;
  logic [7:0] cmd_data = 8'h0, flash_dq_out, flash_dq_in;
  logic [31:0] cmd_pwd = 32'h0, rsp_data;
  logic [2:0] dev_mode;
  int num_errors = 0;
  int comparisons = 0;
  // ****************
  // clock, design and flash
  // ****************
  always #5 clk = ~clk;
  bpc_ctrl dut (.*);
  bpc_flash_model model (.*);
  // compare and count
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check
  // one command, waits for its answer
  task automatic cmd(input logic [3:0] op, input logic [22:0] a, input logic [7:0] d, input logic refused);
    for (int n = 0; n < 50 && cmd_ready !== 1'b1; n++)
      @(negedge clk);
    {cmd_valid, cmd_op, cmd_addr, cmd_data} = {1'b1, op, a, d};
    @(negedge clk);
    cmd_valid = 1'b0;
    for (int n = 0; n < 3000 && rsp_valid !== 1'b1; n++)
      @(negedge clk);
    check("refused", {rsp_valid, rsp_refused}, {1'b1, refused});
  endtask : cmd
  // design and device mode
  task automatic mode_is(input logic [2:0] m);
    check("mode", {dev_mode, model.mode}, {m, m});
  endtask : mode_is
  task automatic t_refuse;
    cmd(4'h7, 23'h0, 8'h0, 1'b1);
    cmd(4'hF, 23'h0, 8'h0, 1'b1);
    cmd(4'h9, 23'h4000, 8'h0, 1'b1);
    cmd(4'h0, 23'h10, 8'h0, 1'b0);
    check("array", rsp_data, 32'h5A);
  endtask : t_refuse
  task automatic t_lock;
    cmd(4'h1, 23'h0, 8'h0, 1'b0);
    mode_is(3'h1);
    cmd(4'h2, 23'h0, 8'h0, 1'b1);
    cmd(4'h0, 23'h0, 8'h0, 1'b1);
    cmd(4'h9, 23'h0, 8'h3C, 1'b0);
    cmd(4'hC, 23'h77, 8'h0, 1'b0);
    check("lock reg", rsp_data, 32'h3C);
    cmd(4'h7, 23'h0, 8'h0, 1'b0);
    mode_is(3'h0);
  endtask : t_lock
  task automatic t_pwd;
    cmd(4'h2, 23'h0, 8'h0, 1'b0);
    mode_is(3'h2);
    cmd(4'h9, 23'h3, 8'hD4, 1'b0);
    cmd(4'h9, 23'h0, 8'hA1, 1'b0);
    cmd(4'h9, 23'h2, 8'hC3, 1'b0);
    cmd(4'h9, 23'h1, 8'hB2, 1'b0);
    cmd(4'hD, 23'h0, 8'h0, 1'b0);
    check("pwd", rsp_data, 32'hD4C3B2A1);
    cmd_pwd = 32'hD4C3B2A1;
    cmd(4'hE, 23'h0, 8'h0, 1'b0);
    cmd(4'hE, 23'h0, 8'h0, 1'b0);
    cmd_pwd = 32'hD4C3B2A0;
    cmd(4'hE, 23'h0, 8'h0, 1'b0);
    check("unlocks", model.unl_cnt, 32'd2);
    cmd(4'h7, 23'h0, 8'h0, 1'b0);
  endtask : t_pwd
  task automatic t_guard;
    cmd(4'h3, 23'h200000, 8'h0, 1'b0);
    mode_is(3'h3);
    cmd(4'h9, 23'h1FFF, 8'h0, 1'b1);
    cmd(4'h9, 23'h4000, 8'h5A, 1'b0);
    cmd(4'hC, 23'h4000, 8'h0, 1'b0);
    check("nv set", rsp_data, 32'h0);
    cmd(4'hB, 23'h0, 8'h0, 1'b0);
    cmd(4'hC, 23'h4000, 8'h0, 1'b0);
    check("nv clr", rsp_data, 32'h1);
    cmd(4'h7, 23'h0, 8'h0, 1'b0);
    cmd(4'h4, 23'h0, 8'h0, 1'b0);
    mode_is(3'h4);
    cmd(4'h9, 23'h0, 8'hFF, 1'b0);
    cmd(4'hC, 23'h200000, 8'h0, 1'b0);
    check("lock bit", rsp_data, 32'h0);
    cmd(4'h7, 23'h0, 8'h0, 1'b0);
  endtask : t_guard
  task automatic t_vol;
    cmd(4'h5, 23'h200000, 8'h0, 1'b0);
    mode_is(3'h5);
    cmd(4'h9, 23'h2000, 8'h0, 1'b0);
    cmd(4'hC, 23'h2000, 8'h0, 1'b0);
    check("vb set", rsp_data, 32'h0);
    cmd(4'hA, 23'h2000, 8'h0, 1'b0);
    cmd(4'hC, 23'h2000, 8'h0, 1'b0);
    check("vb clr", rsp_data, 32'h1);
    cmd(4'hB, 23'h0, 8'h0, 1'b1);
    cmd(4'h7, 23'h0, 8'h0, 1'b0);
  endtask : t_vol
  task automatic t_ext;
    cmd(4'h6, 23'h0, 8'h0, 1'b0);
    cmd(4'h7, 23'h0, 8'h0, 1'b1);
    cmd(4'h9, 23'h10, 8'h77, 1'b0);
    cmd(4'hC, 23'h10, 8'h0, 1'b0);
    check("ext", rsp_data, 32'h77);
    cmd(4'h8, 23'h0, 8'h0, 1'b0);
    mode_is(3'h0);
  endtask : t_ext
  // counts and verdict
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // reset, then the scenarios
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    t_refuse();
    t_lock();
    t_pwd();
    t_guard();
    t_vol();
    t_ext();
    report_and_stop();
  end
  // hang guard
  initial
  begin
    #500us;
    num_errors++;
    report_and_stop();
  end
endmodule : bpc_ctrl_tb
`default_nettype wire
